// file: core/ufb_pkg.sv
package ufb_pkg;
  localparam int          UFB_DW       = 8;
  localparam int          UFB_QDEPTH   = 16;
  localparam int          UFB_QCW      = 5;
  localparam int          UFB_AW       = 12;
  localparam int          UFB_IDX_LSB  = 2;
  localparam int          UFB_IDX_MSB  = 4;
  localparam int          UFB_MAP_LSB  = 5;
  localparam logic [2:0]  UFB_IDX_DATA = 3'h0;
  localparam logic [2:0]  UFB_IDX_DIVL = 3'h0;
  localparam logic [2:0]  UFB_IDX_DIVH = 3'h1;
  localparam logic [2:0]  UFB_IDX_QCTL = 3'h2;
  localparam logic [2:0]  UFB_IDX_LFC  = 3'h3;
  localparam logic [2:0]  UFB_IDX_SCR  = 3'h7;
  localparam int          UFB_QC_EN    = 0;
  localparam int          UFB_QC_RXF   = 1;
  localparam int          UFB_QC_TXF   = 2;
  localparam int          UFB_QC_DMA   = 3;
  localparam int          UFB_QC_TLO   = 6;
  localparam int          UFB_QC_THI   = 7;
  localparam int          UFB_LFC_DAS  = 7;
  localparam logic [7:0]  UFB_QC_KEEP  = 8'hC9;
  localparam logic [7:0]  UFB_QC_RST   = 8'h00;
  localparam logic [7:0]  UFB_LFC_RST  = 8'h00;
  localparam logic [7:0]  UFB_SCR_RST  = 8'h00;
  localparam logic [15:0] UFB_DIV_RST  = 16'h0001;
  localparam logic [7:0]  UFB_ISI_NONE = 8'h01;
  localparam logic [7:0]  UFB_ISI_QON  = 8'hC0;
  localparam logic [1:0]  UFB_TRG_SEL1 = 2'h0;
  localparam logic [1:0]  UFB_TRG_SEL4 = 2'h1;
  localparam logic [1:0]  UFB_TRG_SEL8 = 2'h2;
  localparam logic [4:0]  UFB_TRG_1    = 5'h01;
  localparam logic [4:0]  UFB_TRG_4    = 5'h04;
  localparam logic [4:0]  UFB_TRG_8    = 5'h08;
  localparam logic [4:0]  UFB_TRG_14   = 5'h0E;
endpackage

// file: core/ufb_uart_cfg.sv
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
// Functional notes
// (R1) Write-only queue control register at index 2.
// (R2) Top two bits pick trigger 1/4/8/14.
// (R3) Bit 3 stored only, no DMA outputs.
// (R4) Bit 2 empties transmit queue, self-clears.
// (R5) Bit 1 empties receive queue, self-clears.
// (R6) Bit 0 enables queues; clearing discards contents.
// (R7) Other bits honoured only with enable set.
// (R8) Leaving queue mode clears all control fields.
// (R9) Divisor is two byte registers, index 0/1.
// (R10) Tick divides clock by divisor, 1..65536.
// (R11) Tick is sixteen times the bit rate.
// (R12) Rate scales inversely with divisor value.
// (R13) Scratch byte at index 7, no effect.
// (R14) Divisor reachable only with access select high.
// (R15) Source id top bits read one when enabled.
// (R16) Divisor zero acts as 65536.
// (R17) Each queue holds sixteen entries.
// (R18) Divisor write restarts the baud counter.

module ufb_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             ce,
  input  wire logic             flush,
  input  wire logic             single,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [CW-1:0]               cnt;
  } ufb_q_t;

  ufb_q_t q_r;
  ufb_q_t q_nxt;
  logic   push;
  logic   pop;
  logic   full;

  // In single mode the queue behaves as a one-entry holding register.
  assign full      = single ? (q_r.cnt != '0) : (q_r.cnt == CW'(DEPTH));
  assign in_ready  = !full;
  assign out_valid = (q_r.cnt != '0);
  assign out_data  = q_r.mem[q_r.rp];
  assign level     = q_r.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    q_nxt = q_r;
    if (flush) begin
      // A push in the flush cycle is dropped with the rest.
      q_nxt.wp  = '0;
      q_nxt.rp  = '0;
      q_nxt.cnt = '0;
    end else begin
      if (push) begin
        q_nxt.mem[q_r.wp] = in_data;
        q_nxt.wp = (q_r.wp == AW'(DEPTH-1)) ? '0 : q_r.wp + 1'b1;
      end
      if (pop) begin
        q_nxt.rp = (q_r.rp == AW'(DEPTH-1)) ? '0 : q_r.rp + 1'b1;
      end
      if (push && !pop) begin
        q_nxt.cnt = q_r.cnt + 1'b1;
      end else if (pop && !push) begin
        q_nxt.cnt = q_r.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q_r <= '0;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end
endmodule // ufb_queue

module ufb_uart_cfg
  import ufb_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RESET,
  input  wire logic              CE,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [UFB_AW-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  output logic      [UFB_DW-1:0] TX_DATA,
  output logic                   TX_VALID,
  input  wire logic              TX_READY,
  input  wire logic [UFB_DW-1:0] RX_DATA,
  input  wire logic              RX_VALID,
  output logic                   RX_READY,
  output logic                   BAUD_TICK,
  output logic                   QUEUE_ENABLED,
  output logic                   RX_TRIGGER,
  output logic     [UFB_QCW-1:0] TX_LEVEL,
  output logic     [UFB_QCW-1:0] RX_LEVEL
);
  typedef struct packed {
    logic [15:0] div;
    logic [7:0]  lfc;
    logic [7:0]  scr;
    logic [7:0]  qctl;
    logic [15:0] bcnt;
    logic        tick;
    logic [31:0] rdata;
    logic        pop_ok;
  } ufb_state_t;

  ufb_state_t  s_r;
  ufb_state_t  s_nxt;
  logic [2:0]  idx;
  logic        mapped;
  logic        acc;
  logic        setup;
  logic        wr;
  logic        das;
  logic        qen;
  logic        tx_in_valid;
  logic        tx_in_ready;
  logic        rx_out_valid;
  logic        rx_pop;
  logic [7:0]  rx_head;
  logic        tx_flush;
  logic        rx_flush;
  logic        div_wr;
  logic [4:0]  thr;

  assign idx    = PADDR[UFB_IDX_MSB:UFB_IDX_LSB];
  assign mapped = (PADDR[UFB_AW-1:UFB_MAP_LSB] == '0);
  assign setup  = PSEL && !PENABLE;
  assign acc    = PSEL && PENABLE && PREADY;
  assign wr     = acc && PWRITE && mapped && PSTRB[0];
  assign das    = s_r.lfc[UFB_LFC_DAS];
  assign qen    = s_r.qctl[UFB_QC_EN];

  // Data index writes feed the transmit queue only with access select low.
  assign tx_in_valid = PSEL && PENABLE && PWRITE && mapped && PSTRB[0]
                       && (idx == UFB_IDX_DATA) && !das; // [R14]
  // A full transmit queue stalls the bus instead of losing the byte.
  assign PREADY  = !(tx_in_valid && !tx_in_ready);
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign PRDATA  = s_r.rdata;
  assign rx_pop  = acc && !PWRITE && s_r.pop_ok;
  assign div_wr  = wr && das && ((idx == UFB_IDX_DIVL)
                   || (idx == UFB_IDX_DIVH)); // [R14]

  assign QUEUE_ENABLED = qen;
  assign BAUD_TICK     = s_r.tick;

  // Transmit queue.
  ufb_queue #(.WIDTH(UFB_DW), .DEPTH(UFB_QDEPTH)) u_txq ( // [R17]
    .clk       (CLK),
    .reset     (RESET),
    .ce        (CE),
    .flush     (tx_flush),
    .single    (!qen),
    .in_data   (PWDATA[UFB_DW-1:0]),
    .in_valid  (tx_in_valid),
    .in_ready  (tx_in_ready),
    .out_data  (TX_DATA),
    .out_valid (TX_VALID),
    .out_ready (TX_READY),
    .level     (TX_LEVEL)
  );

  // Receive queue.
  ufb_queue #(.WIDTH(UFB_DW), .DEPTH(UFB_QDEPTH)) u_rxq ( // [R17]
    .clk       (CLK),
    .reset     (RESET),
    .ce        (CE),
    .flush     (rx_flush),
    .single    (!qen),
    .in_data   (RX_DATA),
    .in_valid  (RX_VALID),
    .in_ready  (RX_READY),
    .out_data  (rx_head),
    .out_valid (rx_out_valid),
    .out_ready (rx_pop),
    .level     (RX_LEVEL)
  );

  always_comb begin
    case (s_r.qctl[UFB_QC_THI:UFB_QC_TLO]) // [R2]
      UFB_TRG_SEL1: thr = UFB_TRG_1;
      UFB_TRG_SEL4: thr = UFB_TRG_4;
      UFB_TRG_SEL8: thr = UFB_TRG_8;
      default:      thr = UFB_TRG_14;
    endcase
  end
  assign RX_TRIGGER = qen && (RX_LEVEL >= thr); // [R2]

  always_comb begin
    s_nxt    = s_r;
    tx_flush = 1'b0;
    rx_flush = 1'b0;
    // Read data is captured in the setup phase so it comes from a flop.
    if (setup && !PWRITE) begin
      s_nxt.pop_ok = 1'b0;
      s_nxt.rdata  = '0;
      if (mapped) begin
        case (idx)
          UFB_IDX_DATA: begin
            if (das) begin
              s_nxt.rdata[7:0] = s_r.div[7:0]; // [R9] [R14]
            end else begin
              s_nxt.rdata[7:0] = rx_out_valid ? rx_head : 8'h00;
              s_nxt.pop_ok     = rx_out_valid;
            end
          end
          UFB_IDX_DIVH: begin
            s_nxt.rdata[7:0] = das ? s_r.div[15:8] : 8'h00; // [R9] [R14]
          end
          UFB_IDX_QCTL: begin
            // The control register is write-only; this index reads ids.
            s_nxt.rdata[7:0] = UFB_ISI_NONE
                               | (qen ? UFB_ISI_QON : 8'h00); // [R1] [R15]
          end
          UFB_IDX_LFC: s_nxt.rdata[7:0] = s_r.lfc;
          UFB_IDX_SCR: s_nxt.rdata[7:0] = s_r.scr; // [R13]
          default:     s_nxt.rdata[7:0] = 8'h00;
        endcase
      end
    end
    if (wr) begin
      case (idx)
        UFB_IDX_DIVL: begin
          if (das) begin
            s_nxt.div[7:0] = PWDATA[7:0]; // [R9]
          end
        end
        UFB_IDX_DIVH: begin
          if (das) begin
            s_nxt.div[15:8] = PWDATA[7:0]; // [R9]
          end
        end
        UFB_IDX_QCTL: begin
          if (!PWDATA[UFB_QC_EN]) begin
            // Leaving queue mode drops every field and all contents.
            s_nxt.qctl = UFB_QC_RST; // [R7] [R8]
            tx_flush   = 1'b1; // [R6]
            rx_flush   = 1'b1; // [R6]
          end else begin
            // Flush bits are never stored, so they read back as cleared.
            s_nxt.qctl = PWDATA[7:0] & UFB_QC_KEEP; // [R3] [R4] [R5]
            tx_flush   = PWDATA[UFB_QC_TXF] || !qen; // [R4] [R6]
            rx_flush   = PWDATA[UFB_QC_RXF] || !qen; // [R5] [R6]
          end
        end
        UFB_IDX_LFC: s_nxt.lfc = PWDATA[7:0];
        UFB_IDX_SCR: s_nxt.scr = PWDATA[7:0]; // [R13]
        default: begin
        end
      endcase
    end
    // The tick period equals the divisor in clock cycles.
    if (div_wr) begin
      s_nxt.bcnt = s_nxt.div - 16'h0001; // [R18] [R16]
      s_nxt.tick = 1'b0;
    end else if (s_r.bcnt == 16'h0000) begin
      // Zero minus one wraps to the full 65536-cycle period.
      s_nxt.bcnt = s_r.div - 16'h0001; // [R10] [R16]
      s_nxt.tick = 1'b1; // [R11] [R12]
    end else begin
      s_nxt.bcnt = s_r.bcnt - 16'h0001; // [R10]
      s_nxt.tick = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      s_r       <= '0;
      s_r.div   <= UFB_DIV_RST;
      s_r.lfc   <= UFB_LFC_RST;
      s_r.scr   <= UFB_SCR_RST;
      s_r.qctl  <= UFB_QC_RST;
    end else if (CE) begin
      s_r <= s_nxt;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET || !CE);

  a_off_clears: assert property ( // [R8]
    wr && idx == UFB_IDX_QCTL && !PWDATA[UFB_QC_EN] |=>
      s_r.qctl == UFB_QC_RST && !RX_TRIGGER)
    else $error("control fields not cleared on disable");
  a_disable_drop: assert property ( // [R6]
    wr && idx == UFB_IDX_QCTL && !PWDATA[UFB_QC_EN] |=>
      TX_LEVEL == '0 && RX_LEVEL == '0)
    else $error("queues not emptied on disable");
  a_tx_flush: assert property ( // [R4]
    wr && idx == UFB_IDX_QCTL && PWDATA[UFB_QC_EN] &&
      PWDATA[UFB_QC_TXF] |=> TX_LEVEL == '0 && !s_r.qctl[UFB_QC_TXF])
    else $error("transmit flush failed");
  a_rx_flush: assert property ( // [R5]
    wr && idx == UFB_IDX_QCTL && PWDATA[UFB_QC_EN] &&
      PWDATA[UFB_QC_RXF] |=> RX_LEVEL == '0 && !s_r.qctl[UFB_QC_RXF])
    else $error("receive flush failed");
  a_trig_four: assert property ( // [R2]
    qen && s_r.qctl[UFB_QC_THI:UFB_QC_TLO] == UFB_TRG_SEL4 &&
      RX_LEVEL == 5'h04 |-> RX_TRIGGER)
    else $error("trigger missing at four bytes");
  a_trig_top: assert property ( // [R2]
    qen && s_r.qctl[UFB_QC_THI:UFB_QC_TLO] == 2'h3 &&
      RX_LEVEL == 5'h0D |-> !RX_TRIGGER)
    else $error("trigger early below fourteen bytes");
  a_id_top: assert property ( // [R15]
    setup && !PWRITE && mapped && idx == UFB_IDX_QCTL && qen |=>
      PRDATA[7:6] == 2'h3)
    else $error("id top bits not set");
  a_div_gate: assert property ( // [R14]
    wr && !das && idx == UFB_IDX_DIVL |=> $stable(s_r.div))
    else $error("divisor changed with access select low");
  a_div_restart: assert property ( // [R18]
    div_wr && PWDATA[7:0] == 8'h03 && idx == UFB_IDX_DIVL &&
      s_r.div[15:8] == 8'h00 |=>
      !BAUD_TICK ##1 !BAUD_TICK ##1 !BAUD_TICK)
    else $error("baud counter not restarted");
  a_tick_two: assert property ( // [R10]
    BAUD_TICK && s_r.div == 16'h0002 && !div_wr |=>
      !BAUD_TICK ##1 (BAUD_TICK || $past(div_wr)))
    else $error("tick period wrong for divisor two");
  a_scr_store: assert property ( // [R13]
    wr && idx == UFB_IDX_SCR |=> s_r.scr == $past(PWDATA[7:0]))
    else $error("scratch byte not stored");
  a_tx_stall: assert property (
    tx_in_valid && !tx_in_ready |-> !PREADY)
    else $error("full transmit queue did not stall");

  c_tx_flush: cover property (
    wr && idx == UFB_IDX_QCTL && PWDATA[UFB_QC_TXF] && TX_LEVEL != '0);
  c_trigger: cover property (qen && RX_TRIGGER);
  c_stall: cover property (PSEL && PENABLE && !PREADY);
  c_fast_tick: cover property (BAUD_TICK ##1 BAUD_TICK);
endmodule // ufb_uart_cfg

// file: verif/ufb_far_end.sv
`timescale 1ns/1ps
module ufb_far_end
  import ufb_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              stall,
  input  wire logic              rx_on,
  input  wire logic [UFB_DW-1:0] tx_data,
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  output logic      [UFB_DW-1:0] rx_data,
  output logic                   rx_valid,
  input  wire logic              rx_ready,
  output logic      [UFB_DW-1:0] last_tx,
  output int                     tx_count
);
  logic [UFB_DW-1:0] seq_r;
  // An idle line shows the inverted next byte, so stale data never matches.
  assign rx_data = rx_valid ? seq_r : ~seq_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      seq_r    <= 8'h5A;
      last_tx  <= 8'h00;
      tx_count <= 0;
    end else begin
      tx_ready <= ~stall;
      // The source holds a refused byte and offers it again, so none is lost.
      rx_valid <= rx_on;
      if (rx_valid && rx_ready) begin
        seq_r <= seq_r + 8'h01;
      end
      if (tx_valid && tx_ready) begin
        last_tx  <= tx_data;
        tx_count <= tx_count + 1;
      end
    end
  end
endmodule // ufb_far_end

// file: verif/uart_fifo_ctrl_baud_gen_bench.sv
`timescale 1ns/1ps
module uart_fifo_ctrl_baud_gen_bench;
  import ufb_pkg::*;
  localparam logic [11:0] AD0 = 12'h000;
  localparam logic [11:0] AD1 = 12'h004;
  localparam logic [11:0] AQC = 12'h008;
  localparam logic [11:0] ALF = 12'h00C;
  localparam logic [11:0] ASC = 12'h01C;
  localparam logic [11:0] ABAD = 12'h020;
  logic               CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [UFB_AW-1:0]  PADDR;
  logic [31:0]        PWDATA, PRDATA, q;
  logic               TX_VALID, TX_READY, RX_VALID, RX_READY, e;
  logic               BAUD_TICK, QUEUE_ENABLED, RX_TRIGGER, stall, rx_on;
  logic [UFB_DW-1:0]  TX_DATA, RX_DATA, last_tx, prev;
  logic [UFB_QCW-1:0] TX_LEVEL, RX_LEVEL;
  logic [15:0]        seed;
  logic [15:0]        divs [5];
  int                 tx_count, err_total, cmp_count, thr, lv;

  ufb_uart_cfg dut (.CLK(CLK), .RESET(RESET), .CE(1'b1), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PSTRB(4'hF), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
    .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
    .BAUD_TICK(BAUD_TICK), .QUEUE_ENABLED(QUEUE_ENABLED),
    .RX_TRIGGER(RX_TRIGGER), .TX_LEVEL(TX_LEVEL), .RX_LEVEL(RX_LEVEL));

  ufb_far_end far (.clk(CLK), .reset(RESET), .stall(stall), .rx_on(rx_on),
    .tx_data(TX_DATA), .tx_valid(TX_VALID), .tx_ready(TX_READY),
    .rx_data(RX_DATA), .rx_valid(RX_VALID), .rx_ready(RX_READY),
    .last_tx(last_tx), .tx_count(tx_count));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic int thr_of(input int s);
    return (s == 0) ? 1 : (s == 1) ? 4 : (s == 2) ? 8 : 14;
  endfunction

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic hang(input string what);
    err_total++;
    $display("ERROR %s expected done seen timeout", what);
    print_verdict();
  endtask

  task automatic step();
    @(posedge CLK);
    #1;
  endtask

  // The request is held until PREADY is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] d);
    int n;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= {24'h000000, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      if (++n > 300) hang("pready");
    end while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // Later checks look at the state settled after the landing edge.
    #1;
  endtask

  task automatic wait_rx(input logic [4:0] lvl);
    int n;
    n = 0;
    while (RX_LEVEL !== lvl) begin
      if (++n > 200) hang("rx level");
      step();
    end
  endtask

  // Counted from the restarting divisor write, so one period is enough.
  task automatic tick_gap(input logic [15:0] div);
    int n;
    n = 0;
    do begin
      step();
      n++;
    end while (BAUD_TICK !== 1'b1 && n < 70000);
    check("tick gap", (div == 16'h0000) ? 32'h10000 : {16'h0, div}, n);
  endtask

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  initial begin
    RESET = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = '0;
    PWDATA = '0;
    stall = 1'b0;
    rx_on = 1'b0;
    err_total = 0;
    cmp_count = 0;
    seed = 16'h0003;
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    apb(0, ASC, 8'h00);
    check("scratch reset", 32'h0, q);
    apb(0, AQC, 8'h00);
    check("source id off", {24'h0, UFB_ISI_NONE}, q);
    repeat (4) begin
      seed = lfsr(seed);
      apb(1, ASC, seed[7:0]);
      apb(0, ASC, 8'h00);
      check("scratch", {24'h0, seed[7:0]}, q);
    end
    seed = lfsr(seed);
    divs = '{16'h0001, 16'h0002, 16'h0000, 16'h0100, {8'h01, seed[7:0]}};
    apb(1, ALF, 8'h80);
    apb(0, AD0, 8'h00);
    check("divisor reset", 32'h1, q);
    foreach (divs[i]) begin
      apb(1, AD0, divs[i][7:0]);
      apb(1, AD1, divs[i][15:8]);
      tick_gap(divs[i]);
      apb(0, AD1, 8'h00);
      check("divisor high", {24'h0, divs[i][15:8]}, q);
      apb(0, AD0, 8'h00);
      check("divisor low", {24'h0, divs[i][7:0]}, q);
    end
    apb(1, ALF, 8'h00);
    apb(0, AD1, 8'h00);
    check("divisor hidden", 32'h0, q);
    apb(0, ABAD, 8'h00);
    check("unmapped error", 32'h1, {31'h0, e});
    check("unmapped read", 32'h0, q);
    for (int s = 0; s < 4; s++) begin
      thr = thr_of(s);
      apb(1, AQC, {s[1:0], 6'h07});
      check("rx flushed", 32'h0, {27'h0, RX_LEVEL});
      check("enabled", 32'h1, {31'h0, QUEUE_ENABLED});
      @(posedge CLK) rx_on <= 1'b1;
      wait_rx(5'd16);
      @(posedge CLK) rx_on <= 1'b0;
      #1;
      check("rx refuses", 32'h0, {31'h0, RX_READY});
      for (int j = 0; j <= 17 - thr; j++) begin
        lv = 16 - j;
        check("rx level", lv, {27'h0, RX_LEVEL});
        check("trigger", (lv >= thr), {31'h0, RX_TRIGGER});
        if (j < 17 - thr) begin
          apb(0, AD0, 8'h00);
          if (j > 0) check("rx order", {24'h0, prev + 8'h01}, q);
          prev = q[7:0];
        end
      end
    end
    @(posedge CLK) stall <= 1'b1;
    repeat (3) apb(1, AD0, 8'hA5);
    check("tx level", 32'h3, {27'h0, TX_LEVEL});
    apb(1, AQC, 8'h05);
    check("tx flushed", 32'h0, {27'h0, TX_LEVEL});
    check("rx kept", 32'hD, {27'h0, RX_LEVEL});
    apb(1, AQC, 8'h09);
    check("rx kept", 32'hD, {27'h0, RX_LEVEL});
    check("trigger one", 32'h1, {31'h0, RX_TRIGGER});
    apb(0, AQC, 8'h00);
    check("source id on", {24'h0, UFB_ISI_QON | UFB_ISI_NONE}, q);
    seed = lfsr(seed);
    apb(1, AD0, 8'h3C);
    apb(1, AD0, seed[7:0]);
    @(posedge CLK) stall <= 1'b0;
    for (int n = 0; TX_LEVEL !== 5'd0; n++) begin
      if (n > 100) hang("tx drain");
      step();
    end
    step();
    check("tx last", {24'h0, seed[7:0]}, {24'h0, last_tx});
    check("tx count", 32'h2, tx_count);
    apb(1, AQC, 8'h00);
    check("disabled", 32'h0, {31'h0, QUEUE_ENABLED});
    check("rx dropped", 32'h0, {27'h0, RX_LEVEL});
    apb(1, AQC, 8'hC6);
    check("still off", 32'h0, {31'h0, QUEUE_ENABLED});
    apb(1, AQC, 8'h01);
    @(posedge CLK) rx_on <= 1'b1;
    wait_rx(5'd1);
    @(posedge CLK) rx_on <= 1'b0;
    #1;
    check("threshold cleared", 32'h1, {31'h0, RX_TRIGGER});
    print_verdict();
  end
endmodule // uart_fifo_ctrl_baud_gen_bench
